// File: testbench/tmr_core_tb_top.sv
// Self-checking bench for the 8-bit single-compare timer core.
// Assumes nothing about bus wait states; only the cycle ceiling ends a wait.
`timescale 1ns/1ps
module tmr_core_tb_top
  import tmr_pkg::*;
;
  logic              clk_i;
  logic              reset_n_i;
  logic [TMR_AW-1:0] avm_address_i;
  logic              avm_read_i;
  logic              avm_write_i;
  logic [TMR_BW-1:0] avm_writedata_i;
  logic [TMR_BW-1:0] avm_readdata_o;
  logic              avm_waitrequest_o;
  logic              ext_count_pin_i;
  logic              compare_output_pin_o;
  logic              compare_output_pin_oe_o;
  logic              irq_o;
  int                err_total;
  int                n_compared;
  int                cyc;
  int                highs;
  logic [31:0]       q;
  logic [31:0]       q2;

  `define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

  tmr_core tmr_core_i (
    .clk_i                   (clk_i),
    .reset_n_i               (reset_n_i),
    .avm_address_i           (avm_address_i),
    .avm_read_i              (avm_read_i),
    .avm_write_i             (avm_write_i),
    .avm_writedata_i         (avm_writedata_i),
    .avm_readdata_o          (avm_readdata_o),
    .avm_waitrequest_o       (avm_waitrequest_o),
    .ext_count_pin_i         (ext_count_pin_i),
    .compare_output_pin_o    (compare_output_pin_o),
    .compare_output_pin_oe_o (compare_output_pin_oe_o),
    .irq_o                   (irq_o)
  );

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    avm_address_i   <= a;
    avm_write_i     <= w;
    avm_read_i      <= !w;
    avm_writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (avm_waitrequest_o !== 1'b0);
    r = avm_readdata_o;
    avm_write_i <= 1'b0;
    avm_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] com, input logic [1:0] wgm, input logic [2:0] cs);
    return {25'h0, com, wgm, cs};
  endfunction

  task automatic ext_edges(input int k);
    repeat (k) begin
      @(posedge clk_i);
      ext_count_pin_i <= ~ext_count_pin_i;
      repeat (3) @(posedge clk_i);
      ext_count_pin_i <= ~ext_count_pin_i;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic waitc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Window of four periods plus bus overhead: four or five ticks
  task automatic presc(input logic [2:0] cs, input int per);
    logic [31:0] r;
    wr(TMR_OFS_CNT, 32'h0);
    wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, cs));
    waitc(4 * per);
    wr(TMR_OFS_CTRL, 32'h0);
    rd(TMR_OFS_CNT, r);
    `CHK("prescaled count", 1'b1, r >= 32'h4 && r <= 32'h5)
  endtask

  initial begin
    err_total = 0; n_compared = 0; cyc = 0;
    reset_n_i = 1'b0; avm_address_i = '0; avm_read_i = 1'b0; avm_write_i = 1'b0;
    avm_writedata_i = '0; ext_count_pin_i = 1'b0;
    waitc(4);
    reset_n_i <= 1'b1;
    waitc(3);
    rd(TMR_OFS_CTRL, q); `CHK("ctrl reset", 32'h0, q)
    rd(TMR_OFS_FLAG, q); `CHK("flag reset", 32'h0, q)
    wr(5'h14, 32'hff); rd(5'h14, q); `CHK("unmapped", 32'h0, q)
    wr(TMR_OFS_CNT, 32'h1a5); rd(TMR_OFS_CNT, q); `CHK("cnt width", 32'ha5, q)
    wr(TMR_OFS_CMP, 32'h35a); rd(TMR_OFS_CMP, q); `CHK("cmp width", 32'h5a, q)
    waitc(20); rd(TMR_OFS_CNT, q); `CHK("no source holds", 32'ha5, q)
    // Equal write is blocked at the next tick, so no flag
    wr(TMR_OFS_CMP, 32'h20); wr(TMR_OFS_CNT, 32'h20);
    wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, TMR_CS_DIV1)); waitc(8); wr(TMR_OFS_CTRL, 32'h0);
    rd(TMR_OFS_FLAG, q); `CHK("blocked match", 32'h0, q)
    // Normal mode through compare and wrap
    wr(TMR_OFS_CMP, 32'hf8); wr(TMR_OFS_CNT, 32'hf0);
    wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, TMR_CS_DIV1)); waitc(30); wr(TMR_OFS_CTRL, 32'h0);
    rd(TMR_OFS_FLAG, q); `CHK("both flags", 32'h3, q)
    rd(TMR_OFS_CNT, q); waitc(10); rd(TMR_OFS_CNT, q2); `CHK("stopped cnt", q, q2)
    `CHK("wrapped low", 1'b1, q < 32'h40)
    wr(TMR_OFS_MASK, 32'h2); waitc(3); `CHK("irq cmp", 1'b1, irq_o)
    wr(TMR_OFS_FLAG, 32'h2); rd(TMR_OFS_FLAG, q); `CHK("clear cmp", 32'h1, q)
    waitc(3); `CHK("irq masked ovf", 1'b0, irq_o)
    wr(TMR_OFS_MASK, 32'h1); waitc(3); `CHK("irq ovf", 1'b1, irq_o)
    rd(TMR_OFS_MASK, q); `CHK("mask read", 32'h1, q)
    wr(TMR_OFS_FLAG, 32'h1); rd(TMR_OFS_FLAG, q); `CHK("clear ovf", 32'h0, q)
    waitc(3); `CHK("irq idle", 1'b0, irq_o)
    // Prescaler divide by 8
    wr(TMR_OFS_CNT, 32'h0); wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, TMR_CS_DIV8));
    waitc(80); wr(TMR_OFS_CTRL, 32'h0); rd(TMR_OFS_CNT, q);
    `CHK("div8 count", 1'b1, q >= 32'h9 && q <= 32'hc)
    presc(TMR_CS_DIV64, int'(TMR_PRE_M64) + 1);
    presc(TMR_CS_DIV256, int'(TMR_PRE_M256) + 1);
    presc(TMR_CS_DIV1024, int'(TMR_PRE_M1024) + 1);
    // External rising edges, four, then falling edges, three
    wr(TMR_OFS_CNT, 32'h0); wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, TMR_CS_EXT_RISE));
    ext_edges(4); wr(TMR_OFS_CTRL, 32'h0); rd(TMR_OFS_CNT, q); `CHK("ext rise", 32'h4, q)
    wr(TMR_OFS_CNT, 32'h0); wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, TMR_CS_EXT_FALL));
    ext_edges(3); wr(TMR_OFS_CTRL, 32'h0); rd(TMR_OFS_CNT, q); `CHK("ext fall", 32'h3, q)
    // Clear on compare never passes the compare value
    wr(TMR_OFS_CMP, 32'h09); wr(TMR_OFS_CNT, 32'h0); wr(TMR_OFS_FLAG, 32'h3);
    wr(TMR_OFS_CTRL, ctl(2'h0, 2'h2, TMR_CS_DIV1)); waitc(300); wr(TMR_OFS_CTRL, 32'h0);
    rd(TMR_OFS_CNT, q); `CHK("ctc bound", 1'b1, q <= 32'h09)
    rd(TMR_OFS_FLAG, q); `CHK("ctc flags", 32'h2, q)
    // CPU write wins over counting
    wr(TMR_OFS_CTRL, ctl(2'h0, 2'h0, TMR_CS_DIV1)); wr(TMR_OFS_CNT, 32'h40);
    wr(TMR_OFS_CTRL, 32'h0); rd(TMR_OFS_CNT, q);
    `CHK("write priority", 1'b1, q >= 32'h40 && q <= 32'h48)
    // Forced compare drives the waveform pin
    wr(TMR_OFS_CTRL, 32'h80 | ctl(TMR_COM_TOGGLE, 2'h0, 3'h0)); waitc(3);
    `CHK("oe on", 1'b1, compare_output_pin_oe_o)
    `CHK("toggle", 1'b1, compare_output_pin_o)
    wr(TMR_OFS_CTRL, 32'h80 | ctl(TMR_COM_CLEAR, 2'h0, 3'h0)); waitc(3);
    `CHK("clear pin", 1'b0, compare_output_pin_o)
    wr(TMR_OFS_CTRL, 32'h80 | ctl(TMR_COM_SET, 2'h0, 3'h0)); waitc(3);
    `CHK("set pin", 1'b1, compare_output_pin_o)
    rd(TMR_OFS_CTRL, q); `CHK("strobe reads 0", 32'h60, q)
    // Phase correct: pin spends part of the run high, overflow at bottom
    wr(TMR_OFS_CMP, 32'h80); wr(TMR_OFS_CNT, 32'h10); wr(TMR_OFS_FLAG, 32'h3);
    wr(TMR_OFS_CTRL, ctl(TMR_COM_CLEAR, 2'h1, TMR_CS_DIV1));
    highs = 0;
    repeat (600) begin
      @(posedge clk_i);
      if (compare_output_pin_o === 1'b1) highs++;
    end
    wr(TMR_OFS_CTRL, 32'h0);
    `CHK("pwm duty", 1'b1, highs > 50 && highs < 550)
    rd(TMR_OFS_FLAG, q); `CHK("pwm ovf", 1'b1, q[0])
    // Fast PWM: pin set at BOTTOM, a new compare value waits for MAX
    wr(TMR_OFS_CNT, 32'hf0);
    wr(TMR_OFS_FLAG, 32'h3);
    wr(TMR_OFS_CTRL, ctl(TMR_COM_CLEAR, 2'h3, TMR_CS_DIV1));
    waitc(30);
    `CHK("fast pwm bottom", 1'b1, compare_output_pin_o)
    wr(TMR_OFS_CMP, 32'h60);
    waitc(97);
    `CHK("fast pwm buffered", 1'b1, compare_output_pin_o)
    waitc(30);
    `CHK("fast pwm match", 1'b0, compare_output_pin_o)
    rd(TMR_OFS_CMP, q);
    `CHK("cmp buffer read", 32'h60, q)
    rd(TMR_OFS_FLAG, q);
    `CHK("fast pwm flags", 32'h3, q)
    wr(TMR_OFS_CTRL, 32'h0); waitc(3);
    `CHK("oe off", 1'b0, compare_output_pin_oe_o)
    end_of_test();
  end
endmodule

// File: verilog/tmr_clk_sel.sv
// Clock selection: prescaled system clock or edges of the external count pin.
// Assumes the count pin is already synchronous to clk_i.
`timescale 1ns/1ps
module tmr_clk_sel
  import tmr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] cs_i,
  input  wire logic       ext_pin_i,
  output logic            tick_o
);

  logic [TMR_PRE_W-1:0] pre;
  logic                 ext_q;
  logic                 next_tick;
  wire                  ext_rise = ext_pin_i & ~ext_q;
  wire                  ext_fall = ~ext_pin_i & ext_q;

  // Prescaler free-runs; taps fire when the low bits are all ones
  always_comb begin
    unique case (cs_i)
      TMR_CS_OFF:      next_tick = 1'b0;
      TMR_CS_DIV1:     next_tick = 1'b1;
      TMR_CS_DIV8:     next_tick = (pre & TMR_PRE_M8) == TMR_PRE_M8;
      TMR_CS_DIV64:    next_tick = (pre & TMR_PRE_M64) == TMR_PRE_M64;
      TMR_CS_DIV256:   next_tick = (pre & TMR_PRE_M256) == TMR_PRE_M256;
      TMR_CS_DIV1024:  next_tick = pre == TMR_PRE_M1024;
      TMR_CS_EXT_FALL: next_tick = ext_fall;
      TMR_CS_EXT_RISE: next_tick = ext_rise;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre    <= '0;
      ext_q  <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      pre    <= pre + TMR_PRE_W'(1);
      ext_q  <= ext_pin_i;
      tick_o <= next_tick;
    end
  end

endmodule

// File: verilog/tmr_core.sv
// 8-bit timer/counter with one compare unit behind an Avalon-MM slave.
// Assumes clk_i at 100 MHz and a count pin synchronous to clk_i.
`timescale 1ns/1ps
module tmr_core
  import tmr_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [TMR_AW-1:0] avm_address_i,
  input  wire logic              avm_read_i,
  input  wire logic              avm_write_i,
  input  wire logic [TMR_BW-1:0] avm_writedata_i,
  output logic      [TMR_BW-1:0] avm_readdata_o,
  output logic                   avm_waitrequest_o,
  input  wire logic              ext_count_pin_i,
  output logic                   compare_output_pin_o,
  output logic                   compare_output_pin_oe_o,
  output logic                   irq_o
);

  logic       rst_meta;
  logic       rst_n;
  tmr_ctrl_t  timer_ctrl_reg_a;
  logic [7:0] counter_value;
  logic [7:0] compare_value_reg;
  logic [7:0] cmp_active;
  tmr_flag_t  timer_flag_reg;
  tmr_flag_t  timer_mask_reg;
  tmr_dir_t   dir;
  logic       block;
  logic       oc;
  logic       timer_tick;

  logic [7:0]      next_cnt;
  tmr_dir_t        next_dir;
  logic            ovf_ev;
  logic            next_oc;
  logic [TMR_BW-1:0] next_rdata;

  // Reset release through two flops; only rst_n is used downstream
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Bus decode; a request is answered one cycle after it is seen
  wire req      = avm_read_i | avm_write_i;
  wire wr_en    = avm_write_i & ~avm_waitrequest_o;
  wire hit_ctrl = avm_address_i == TMR_OFS_CTRL;
  wire hit_cnt  = avm_address_i == TMR_OFS_CNT;
  wire hit_cmp  = avm_address_i == TMR_OFS_CMP;
  wire hit_flag = avm_address_i == TMR_OFS_FLAG;
  wire hit_mask = avm_address_i == TMR_OFS_MASK;
  wire wr_ctrl  = wr_en & hit_ctrl;
  wire wr_cnt   = wr_en & hit_cnt;
  wire wr_cmp   = wr_en & hit_cmp;
  wire wr_flag  = wr_en & hit_flag;
  wire wr_mask  = wr_en & hit_mask;

  // Field decode
  wire tmr_wgm_t   wgm      = timer_ctrl_reg_a.wgm;
  // Output mode written together with the force strobe acts at once
  wire tmr_ctrl_t  ctrl_wdata = tmr_ctrl_t'(avm_writedata_i[TMR_CTRL_W-1:0]);
  wire logic [1:0] com      = wr_ctrl ? ctrl_wdata.com : timer_ctrl_reg_a.com;
  wire             is_pwm   = (wgm == TMR_WGM_PWM_PC) | (wgm == TMR_WGM_PWM_FAST);
  wire logic [7:0] top_val  = (wgm == TMR_WGM_CTC) ? cmp_active : TMR_MAX;
  wire             at_bot   = counter_value == TMR_BOTTOM;
  wire             at_max   = counter_value == TMR_MAX;
  wire             at_top   = counter_value == top_val;
  wire             equal    = counter_value == cmp_active;
  wire             cmp_ev   = timer_tick & equal & ~block;
  wire             buf_load = timer_tick & is_pwm & at_max;
  wire             force_oc = wr_ctrl & avm_writedata_i[TMR_FOC_BIT] & ~is_pwm;
  wire tmr_flag_t  clr_mask = wr_flag ? tmr_flag_t'(avm_writedata_i[TMR_FLAG_W-1:0]) : '0;

  tmr_clk_sel u_clk_sel (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .cs_i      (timer_ctrl_reg_a.cs),
    .ext_pin_i (ext_count_pin_i),
    .tick_o    (timer_tick)
  );

  // Count sequence per mode
  always_comb begin
    next_cnt = counter_value;
    next_dir = dir;
    ovf_ev   = 1'b0;
    if (timer_tick) begin
      unique case (wgm)
        TMR_WGM_NORMAL, TMR_WGM_PWM_FAST: begin
          next_cnt = counter_value + TMR_STEP;
          ovf_ev   = at_max;
        end
        TMR_WGM_CTC: begin
          next_cnt = at_top ? TMR_BOTTOM : counter_value + TMR_STEP;
          ovf_ev   = at_max;
        end
        TMR_WGM_PWM_PC: begin
          if (dir == TMR_DIR_UP) begin
            if (at_max) begin
              next_dir = TMR_DIR_DOWN;
              next_cnt = counter_value - TMR_STEP;
            end else begin
              next_cnt = counter_value + TMR_STEP;
            end
          end else begin
            if (at_bot) begin
              next_dir = TMR_DIR_UP;
              next_cnt = counter_value + TMR_STEP;
              ovf_ev   = 1'b1;
            end else begin
              next_cnt = counter_value - TMR_STEP;
            end
          end
        end
      endcase
    end
    if (wr_cnt) begin
      next_cnt = avm_writedata_i[7:0];
    end
  end

  // Waveform generator
  always_comb begin
    next_oc = oc;
    if (cmp_ev | force_oc) begin
      unique case (wgm)
        TMR_WGM_NORMAL, TMR_WGM_CTC: begin
          unique case (com)
            TMR_COM_OFF:    next_oc = oc;
            TMR_COM_TOGGLE: next_oc = ~oc;
            TMR_COM_CLEAR:  next_oc = 1'b0;
            TMR_COM_SET:    next_oc = 1'b1;
          endcase
        end
        TMR_WGM_PWM_FAST: begin
          if (com == TMR_COM_CLEAR) next_oc = 1'b0;
          if (com == TMR_COM_SET) next_oc = 1'b1;
        end
        TMR_WGM_PWM_PC: begin
          // Clear on the way up, set on the way down: symmetric pulses
          if (com == TMR_COM_CLEAR) next_oc = (dir == TMR_DIR_DOWN);
          if (com == TMR_COM_SET) next_oc = (dir == TMR_DIR_UP);
        end
      endcase
    end
    // Fast PWM restarts the pulse at BOTTOM; this wins over a match at MAX
    if (timer_tick & at_max & (wgm == TMR_WGM_PWM_FAST)) begin
      if (com == TMR_COM_CLEAR) next_oc = 1'b1;
      if (com == TMR_COM_SET) next_oc = 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (hit_ctrl) next_rdata[TMR_CTRL_W-1:0] = timer_ctrl_reg_a;
    if (hit_cnt) next_rdata[7:0] = counter_value;
    if (hit_cmp) next_rdata[7:0] = compare_value_reg;
    if (hit_flag) next_rdata[TMR_FLAG_W-1:0] = timer_flag_reg;
    if (hit_mask) next_rdata[TMR_FLAG_W-1:0] = timer_mask_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avm_waitrequest_o <= 1'b1;
      avm_readdata_o    <= '0;
    end else begin
      avm_waitrequest_o <= ~(req & avm_waitrequest_o);
      if (req & avm_waitrequest_o) avm_readdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_ctrl_reg_a <= '0;
      timer_mask_reg   <= '0;
    end else begin
      if (wr_ctrl) timer_ctrl_reg_a <= tmr_ctrl_t'(avm_writedata_i[TMR_CTRL_W-1:0]);
      if (wr_mask) timer_mask_reg <= tmr_flag_t'(avm_writedata_i[TMR_FLAG_W-1:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= TMR_BOTTOM;
      dir           <= TMR_DIR_UP;
      block         <= 1'b0;
    end else begin
      counter_value <= next_cnt;
      dir           <= next_dir;
      // A counter write hides the match on the following tick
      block         <= wr_cnt | (block & ~timer_tick);
    end
  end

  // Double buffer: PWM modes load the active value only at TOP
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_reg <= TMR_BOTTOM;
      cmp_active        <= TMR_BOTTOM;
    end else begin
      if (wr_cmp) compare_value_reg <= avm_writedata_i[7:0];
      if (wr_cmp & ~is_pwm) cmp_active <= avm_writedata_i[7:0];
      else if (buf_load) cmp_active <= compare_value_reg;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_flag_reg <= '0;
    end else begin
      timer_flag_reg.cmp <= (timer_flag_reg.cmp & ~clr_mask.cmp) | cmp_ev;
      timer_flag_reg.ovf <= (timer_flag_reg.ovf & ~clr_mask.ovf) | ovf_ev;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oc                      <= 1'b0;
      compare_output_pin_o    <= 1'b0;
      compare_output_pin_oe_o <= 1'b0;
      irq_o                   <= 1'b0;
    end else begin
      oc                      <= next_oc;
      compare_output_pin_o    <= next_oc;
      compare_output_pin_oe_o <= com != TMR_COM_OFF;
      irq_o                   <= |(timer_flag_reg & timer_mask_reg);
    end
  end

  AST_BUS_ANSWER: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (req & avm_waitrequest_o) |=> !avm_waitrequest_o
  ) else $error("bus request not answered in one cycle");

  AST_CNT_WRITE_WINS: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    wr_cnt |=> counter_value == $past(avm_writedata_i[7:0])
  ) else $error("counter write lost to count");

  AST_STOPPED: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    ((timer_ctrl_reg_a.cs == TMR_CS_OFF) & !wr_cnt & !wr_ctrl)[*2]
      |=> !timer_tick && $stable(counter_value)
  ) else $error("counter moved with no clock source");

  AST_CMP_FLAG: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (timer_tick && equal && !block) |=> timer_flag_reg.cmp
  ) else $error("compare flag not set after match tick");

  AST_OVF_WRAP: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (timer_tick && wgm == TMR_WGM_NORMAL && at_max && !wr_cnt)
      |=> counter_value == TMR_BOTTOM && timer_flag_reg.ovf
  ) else $error("normal mode wrap without overflow");

  AST_CTC_CLEAR: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (timer_tick && wgm == TMR_WGM_CTC && equal && !wr_cnt) |=> counter_value == TMR_BOTTOM
  ) else $error("counter not cleared on compare");

  AST_FLAG_CLEAR: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (wr_flag && avm_writedata_i[1] && !cmp_ev) |=> !timer_flag_reg.cmp
  ) else $error("compare flag not cleared by write");

  AST_PC_TURN: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (timer_tick && wgm == TMR_WGM_PWM_PC && dir == TMR_DIR_UP && at_max && !wr_cnt)
      |=> dir == TMR_DIR_DOWN && counter_value == TMR_MAX - TMR_STEP
  ) else $error("phase correct count did not turn at MAX");

  AST_MASKED: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    (timer_mask_reg == '0)[*2] |-> !irq_o
  ) else $error("interrupt raised while fully masked");

endmodule

// File: verilog/tmr_pkg.sv
// Shared constants and types for the 8-bit single-compare timer.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
package tmr_pkg;

  localparam int TMR_AW = 5;
  localparam int TMR_BW = 32;

  // Register byte offsets
  localparam logic [TMR_AW-1:0] TMR_OFS_CTRL = 5'h00;
  localparam logic [TMR_AW-1:0] TMR_OFS_CNT  = 5'h04;
  localparam logic [TMR_AW-1:0] TMR_OFS_CMP  = 5'h08;
  localparam logic [TMR_AW-1:0] TMR_OFS_FLAG = 5'h0c;
  localparam logic [TMR_AW-1:0] TMR_OFS_MASK = 5'h10;

  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_MAX    = 8'hff;
  localparam logic [7:0] TMR_STEP   = 8'h01;

  localparam logic [2:0] TMR_CS_OFF      = 3'h0;
  localparam logic [2:0] TMR_CS_DIV1     = 3'h1;
  localparam logic [2:0] TMR_CS_DIV8     = 3'h2;
  localparam logic [2:0] TMR_CS_DIV64    = 3'h3;
  localparam logic [2:0] TMR_CS_DIV256   = 3'h4;
  localparam logic [2:0] TMR_CS_DIV1024  = 3'h5;
  localparam logic [2:0] TMR_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR_CS_EXT_RISE = 3'h7;

  localparam int         TMR_PRE_W      = 10;
  localparam logic [9:0] TMR_PRE_M8     = 10'h007;
  localparam logic [9:0] TMR_PRE_M64    = 10'h03f;
  localparam logic [9:0] TMR_PRE_M256   = 10'h0ff;
  localparam logic [9:0] TMR_PRE_M1024  = 10'h3ff;

  localparam logic [1:0] TMR_COM_OFF    = 2'h0;
  localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TMR_COM_SET    = 2'h3;

  localparam int TMR_FOC_BIT = 7;

  typedef enum logic [1:0] {
    TMR_WGM_NORMAL,
    TMR_WGM_PWM_PC,
    TMR_WGM_CTC,
    TMR_WGM_PWM_FAST
  } tmr_wgm_t;

  typedef enum logic {
    TMR_DIR_UP,
    TMR_DIR_DOWN
  } tmr_dir_t;

  // Control register A layout, low bits of the word
  typedef struct packed {
    logic [1:0] com;
    tmr_wgm_t   wgm;
    logic [2:0] cs;
  } tmr_ctrl_t;

  // Flag and mask layout: bit1 compare, bit0 overflow
  typedef struct packed {
    logic cmp;
    logic ovf;
  } tmr_flag_t;

  localparam int TMR_CTRL_W = 7;
  localparam int TMR_FLAG_W = 2;

endpackage
